// File: chan_if.sv
// Bundle between the register file and one timer channel.
`default_nettype none

interface chan_if;
    import quad_timer_pkg::*;
    logic en;
    mode_t mode;
    logic [PSC_W-1:0] prescale;
    logic [CNT_W-1:0] compare;
    logic restart;
    logic src_tick;
    logic [CNT_W-1:0] count;
    logic match;
    logic toggle;

    modport cfg (output en, mode, prescale, compare, restart, src_tick,
                 input count, match, toggle);
    modport chan (input en, mode, prescale, compare, restart, src_tick,
                  output count, match, toggle);
endinterface : chan_if

`default_nettype wire

// File: clk_source_sel.sv
// Per-channel count source: system clock, slow divided tick or a pin edge.
`default_nettype none

module clk_source_sel import quad_timer_pkg::*; #(
    parameter int SLOW_DIV_P = SLOW_DIV
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] sel_in,
    input wire logic pin_in,
    output logic tick_out
);
    localparam int DIV_W = $clog2(SLOW_DIV_P + 1);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic [DIV_W-1:0] div_q;
    logic slow_tick;
    logic pin_rise;

    // ------------------------------------------------------------------
    // Pin synchroniser; only the second stage feeds the edge detector.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign pin_rise = sync2_q && !prev_q;

    // Free-running divider, so switching source never waits for a restart.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= '0;
        end else if (slow_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    assign slow_tick = (div_q == DIV_W'(SLOW_DIV_P - 1));

    // Source choice; the fourth code gives no ticks at all.
    always_comb begin
        case (sel_in)
            SRC_SYS: tick_out = 1'b1;
            SRC_SLOW: tick_out = slow_tick;
            SRC_PIN: tick_out = pin_rise;
            default: tick_out = 1'b0;
        endcase
    end
endmodule // clk_source_sel

`default_nettype wire

// File: irq_partner.sv
// Interrupt controller and external tick source that face the timer.
`default_nettype none

module irq_partner (
    input wire logic clk_in,
    input wire logic irq_in,
    output logic [3:0] pin_out,
    output int rises_out
);
    logic irq_q = 1'b0;
    logic [1:0] ph_q = 2'b00;
    int n_q = 0;

    // -----------------------------------------------------------------
    // Edge counting and pin pattern
    // -----------------------------------------------------------------
    // A controller that counts rising edges catches a level that never drops.
    always_ff @(posedge clk_in) begin
        ph_q <= ph_q + 2'b01;
        irq_q <= irq_in;
        if (irq_in && !irq_q) begin
            n_q <= n_q + 1;
        end
    end

    // Pins rise once every four cycles, one edge per counted tick.
    assign pin_out = {4{ph_q[1]}};
    assign rises_out = n_q;
endmodule // irq_partner

`default_nettype wire

// File: quad_timer.sv
// Top of the four-channel prescaled up-timer with its Wishbone register file.
//
// Our own choices: the register offsets and register access over Wishbone.
`default_nettype none

module quad_timer import quad_timer_pkg::*; #(
    parameter int SLOW_DIV_P = SLOW_DIV
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output var logic [31:0] WB_DAT_OUT,
    output var logic WB_ACK_OUT,
    input wire logic [NUM_CH-1:0] TICK_PIN_IN,
    output var logic [NUM_CH-1:0] TOGGLE_OUT,
    output var logic [NUM_CH-1:0] CHAN_IRQ_OUT,
    output var logic IRQ_OUT
);
    logic bus_go;
    logic wr_go;
    logic wr_stat;
    logic wr_mask;
    logic [31:0] rd_data;
    logic [NUM_CH-1:0] mask_q;
    logic [NUM_CH-1:0] mask_d;
    logic [31:0] mask_word;
    wire [NUM_CH-1:0][31:0] ctrl_word;
    wire [NUM_CH-1:0][31:0] cmp_word;
    wire [NUM_CH-1:0][31:0] snap_word;
    wire [NUM_CH-1:0][31:0] src_word;
    wire [NUM_CH-1:0] flag_w;
    wire [NUM_CH-1:0] ie_w;
    wire [NUM_CH-1:0] toggle_w;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------

    // Byte-lane merge so a partial write leaves other lanes untouched.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // True when the address selects the given register of the given channel.
    function automatic logic hit_reg(input logic [ADR_W-1:0] adr, input int ch,
                                     input logic [4:0] ofs);
        return !adr[7] && (adr[6:5] == 2'(ch)) && (adr[4:0] == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Wishbone slave: one wait state, ack is a single-cycle pulse
    // ------------------------------------------------------------------
    assign bus_go = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    assign wr_go = bus_go && WB_WE_IN;
    assign wr_stat = wr_go && (WB_ADR_IN == OFS_IRQ_STAT);
    assign wr_mask = wr_go && (WB_ADR_IN == OFS_IRQ_MASK);

    // Ack and read data are taken together; unmapped reads return zero.
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h0;
        end else begin
            WB_ACK_OUT <= bus_go;
            if (bus_go) begin
                WB_DAT_OUT <= WB_WE_IN ? 32'h0 : rd_data;
            end
        end
    end

    // Read multiplexer over the channel windows and the global pair.
    always_comb begin
        rd_data = 32'h0;
        if (WB_ADR_IN == OFS_IRQ_STAT) begin
            rd_data = {28'h0, flag_w};
        end else if (WB_ADR_IN == OFS_IRQ_MASK) begin
            rd_data = {28'h0, mask_q};
        end else if (!WB_ADR_IN[7]) begin
            case (WB_ADR_IN[4:0])
                OFS_CTRL: rd_data = ctrl_word[WB_ADR_IN[6:5]];
                OFS_CMP: rd_data = cmp_word[WB_ADR_IN[6:5]];
                OFS_FLAG: rd_data = {31'h0, flag_w[WB_ADR_IN[6:5]]};
                OFS_SNAP: rd_data = snap_word[WB_ADR_IN[6:5]];
                OFS_SRC: rd_data = src_word[WB_ADR_IN[6:5]];
                default: rd_data = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt mask and outputs
    // ------------------------------------------------------------------
    // A function result cannot be part-selected, so the merged word is named first.
    assign mask_word = merge_bytes({28'h0, mask_q}, WB_DAT_IN, WB_SEL_IN);
    assign mask_d = mask_word[NUM_CH-1:0];

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mask_q <= MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= mask_d;
        end
    end

    // Registered outputs cost one cycle of latency but never glitch.
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CHAN_IRQ_OUT <= '0;
            IRQ_OUT <= 1'b0;
            TOGGLE_OUT <= '0;
        end else begin
            CHAN_IRQ_OUT <= flag_w & ie_w;
            IRQ_OUT <= |(flag_w & ie_w & mask_q);
            TOGGLE_OUT <= toggle_w;
        end
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    chan_if ch_bus[NUM_CH] ();

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic cen_q;
        logic ie_q;
        logic snap_en_q;
        logic flag_q;
        mode_t mode_q;
        logic [PSC_W-1:0] psc_q;
        logic [CNT_W-1:0] cmp_q;
        logic [CNT_W-1:0] snap_q;
        logic [1:0] src_q;
        logic [31:0] ctrl_d;
        logic [31:0] cmp_d;
        logic [31:0] src_d;
        logic wr_ctrl;
        logic wr_cmp;
        logic wr_flag;
        logic wr_src;
        logic clr_flag;
        logic tick_w;

        assign wr_ctrl = wr_go && hit_reg(WB_ADR_IN, i, OFS_CTRL);
        assign wr_cmp = wr_go && hit_reg(WB_ADR_IN, i, OFS_CMP);
        assign wr_flag = wr_go && hit_reg(WB_ADR_IN, i, OFS_FLAG);
        assign wr_src = wr_go && hit_reg(WB_ADR_IN, i, OFS_SRC);
        assign ctrl_d = merge_bytes(ctrl_word[i], WB_DAT_IN, WB_SEL_IN);
        assign cmp_d = merge_bytes(cmp_word[i], WB_DAT_IN, WB_SEL_IN);
        assign src_d = merge_bytes(src_word[i], WB_DAT_IN, WB_SEL_IN);
        assign clr_flag = (wr_flag && WB_SEL_IN[0] && WB_DAT_IN[0])
                       || (wr_stat && WB_SEL_IN[0] && WB_DAT_IN[i]);

        // Control word; a software write in the match cycle wins over the stop.
        always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                cen_q <= CTRL_RESET[BIT_CEN];
                ie_q <= CTRL_RESET[BIT_IE];
                mode_q <= mode_t'(CTRL_RESET[MODE_HI:MODE_LO]);
                snap_en_q <= CTRL_RESET[BIT_SNAP_EN];
                psc_q <= CTRL_RESET[PSC_HI:0];
            end else if (wr_ctrl) begin
                cen_q <= ctrl_d[BIT_CEN] && !ctrl_d[BIT_CRST];
                ie_q <= ctrl_d[BIT_IE];
                mode_q <= mode_t'(ctrl_d[MODE_HI:MODE_LO]);
                snap_en_q <= ctrl_d[BIT_SNAP_EN];
                psc_q <= ctrl_d[PSC_HI:0];
            end else if (ch_bus[i].match && mode_q == MODE_ONE_SHOT) begin
                cen_q <= 1'b0;
            end
        end

        // Compare value and source select.
        always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                cmp_q <= '0;
                src_q <= SRC_SYS;
            end else begin
                if (wr_cmp) begin
                    cmp_q <= cmp_d[CNT_W-1:0];
                end
                if (wr_src) begin
                    src_q <= src_d[1:0];
                end
            end
        end

        // Match flag: a match in the clearing cycle keeps the flag set.
        always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                flag_q <= 1'b0;
            end else if (ch_bus[i].match) begin
                flag_q <= 1'b1;
            end else if (clr_flag) begin
                flag_q <= 1'b0;
            end
        end

        // Snapshot follows the counter while updates are enabled.
        always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                snap_q <= '0;
            end else if (snap_en_q) begin
                snap_q <= ch_bus[i].count;
            end
        end

        clk_source_sel #(.SLOW_DIV_P(SLOW_DIV_P)) u_src (
            .clk_in(CLOCK_IN),
            .rst_in(RST_IN),
            .sel_in(src_q),
            .pin_in(TICK_PIN_IN[i]),
            .tick_out(tick_w)
        );

        assign ch_bus[i].en = cen_q;
        assign ch_bus[i].mode = mode_q;
        assign ch_bus[i].prescale = psc_q;
        assign ch_bus[i].compare = cmp_q;
        assign ch_bus[i].src_tick = tick_w;
        assign ch_bus[i].restart = (wr_ctrl && ctrl_d[BIT_CRST])
                                || (wr_cmp && mode_q != MODE_CONTINUOUS);

        timer_channel u_chan (
            .clk_in(CLOCK_IN),
            .rst_in(RST_IN),
            .bus(ch_bus[i])
        );

        assign ctrl_word[i] = {1'b0, cen_q, ie_q, mode_q, 1'b0, cen_q, 8'h0,
                               snap_en_q, 8'h0, psc_q};
        assign cmp_word[i] = {8'h0, cmp_q};
        assign snap_word[i] = {8'h0, snap_q};
        assign src_word[i] = {30'h0, src_q};
        assign flag_w[i] = flag_q;
        assign ie_w[i] = ie_q;
        assign toggle_w[i] = ch_bus[i].toggle;

        // Checks for this channel.
        sequence s_oneshot_hit;
            ch_bus[i].match && mode_q == MODE_ONE_SHOT && !wr_ctrl;
        endsequence

        a_oneshot_stop: assert property (s_oneshot_hit |=> (!cen_q && flag_q))
            else $error("one-shot match did not stop the channel");
        a_flag_set: assert property (ch_bus[i].match |=> flag_q)
            else $error("match did not set the flag");
        a_flag_clear: assert property (
            (clr_flag && !ch_bus[i].match) |=> !flag_q)
            else $error("write of one did not clear the flag");
        a_cmp_restart: assert property (
            (wr_cmp && mode_q != MODE_CONTINUOUS) |=> (ch_bus[i].count == '0))
            else $error("compare write did not restart the counter");
        a_irq_gate: assert property (
            (flag_q && !ie_q) ##1 (!$past(ie_q) || !ie_q) |-> !CHAN_IRQ_OUT[i])
            else $error("interrupt raised with interrupt enable clear");
    end

    a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held for more than one cycle");
    a_ack_follows: assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT)
        else $error("request not answered in one cycle");
endmodule // quad_timer

`default_nettype wire

// File: quad_timer_pkg.sv
// Shared constants, field positions and types of the four-channel timer.
`default_nettype none

package quad_timer_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int CNT_W = 24;
    localparam int PSC_W = 8;
    localparam int ADR_W = 8;

    // ------------------------------------------------------------------
    // Register offsets: per channel inside a 32-byte window, plus globals
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_CMP = 5'h04;
    localparam logic [4:0] OFS_FLAG = 5'h08;
    localparam logic [4:0] OFS_SNAP = 5'h0c;
    localparam logic [4:0] OFS_SRC = 5'h10;
    localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h80;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h84;

    // ------------------------------------------------------------------
    // Fields of channel_control_status
    // ------------------------------------------------------------------
    localparam int BIT_CEN = 30;
    localparam int BIT_IE = 29;
    localparam int MODE_HI = 28;
    localparam int MODE_LO = 27;
    localparam int BIT_CRST = 26;
    localparam int BIT_ACT = 25;
    localparam int BIT_SNAP_EN = 16;
    localparam int PSC_HI = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0005;
    localparam logic [NUM_CH-1:0] MASK_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Timing: slow source tick period and its cycle count
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SLOW_TICK_NS = 1000;
    localparam int SLOW_DIV = SLOW_TICK_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ONE_SHOT = 2'b00,
        MODE_PERIODIC = 2'b01,
        MODE_TOGGLE = 2'b10,
        MODE_CONTINUOUS = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        SRC_SYS = 2'b00,
        SRC_SLOW = 2'b01,
        SRC_PIN = 2'b10
    } src_t;

endpackage : quad_timer_pkg

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the four-channel timer.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import quad_timer_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0] wdat = '0, dat_o;
    logic [3:0] pins, tog, cirq;
    logic [63:0] exp_q[$];
    logic [63:0] e_q;
    int rises, mismatches = 0, tests_run = 0, cycle_n = 0, seed = 53615;

    quad_timer #(.SLOW_DIV_P(2)) u_dut (.CLOCK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf),
        .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_o), .WB_ACK_OUT(ack), .TICK_PIN_IN(pins),
        .TOGGLE_OUT(tog), .CHAN_IRQ_OUT(cirq), .IRQ_OUT(irq));
    irq_partner u_partner (.clk_in(clk), .irq_in(irq), .pin_out(pins), .rises_out(rises));

    // 25 MHz clock and a free cycle count for interval checks.
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycle_n <= cycle_n + 1;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each read ack is matched with the oldest noted value, under its mask.
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e_q = exp_q.pop_front();
            check("read data", dat_o & e_q[63:32], e_q[31:0]);
        end
    end

    function automatic logic [7:0] adr_of(input int ch, input logic [4:0] ofs);
        return {ch[2:0], ofs};
    endfunction

    function automatic logic [31:0] ctl(input logic en, input logic ie, input logic [1:0] md,
                                        input logic sn, input logic [7:0] p);
        return {1'b0, en, ie, md, 10'h0, sn, 8'h0, p};
    endfunction

    // One classic cycle; the read note is queued before the ack can land.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, output logic [31:0] q);
        int n;
        n = 0;
        if (!w) begin
            exp_q.push_back({m, d & m});
        end
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) begin
            mismatches++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    // Spacing between two toggle edges; the first edge may close a partial period.
    task automatic period(input int ch, input int exp);
        int t0, n;
        logic v;
        n = 0;
        v = tog[ch];
        while (tog[ch] === v && n < 500) begin
            @(posedge clk);
            n++;
        end
        t0 = cycle_n;
        v = tog[ch];
        while (tog[ch] === v && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("toggle period", cycle_n - t0, exp);
    endtask

    task automatic finish_test();
        $display("counts: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A hang well past the expected run length ends the test as a failure.
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end

    initial begin
        logic [31:0] q, s1, s2, c0;
        int n;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int ch = 0; ch < 4; ch++) begin
            bus(0, adr_of(ch, OFS_CTRL), CTRL_RESET, '1, q);
            bus(0, adr_of(ch, OFS_CMP), 0, '1, q);
            bus(0, adr_of(ch, OFS_FLAG), 0, '1, q);
        end
        bus(0, OFS_IRQ_MASK, 0, '1, q);
        bus(1, adr_of(0, OFS_SNAP), 32'h1234, 0, q);
        bus(0, adr_of(0, 5'h14), 0, '1, q);
        bus(0, adr_of(0, OFS_SNAP), 0, '1, q);
        $display("test reset values done");
        // Three sources at once: system clock, slow tick and pin edges.
        c0 = 2 + ({$random(seed)} % 8);
        bus(1, adr_of(1, OFS_SRC), SRC_SLOW, 0, q);
        bus(1, adr_of(2, OFS_SRC), SRC_PIN, 0, q);
        bus(1, adr_of(0, OFS_CMP), c0, 0, q);
        bus(1, adr_of(1, OFS_CMP), 4, 0, q);
        bus(1, adr_of(2, OFS_CMP), 3, 0, q);
        bus(1, adr_of(0, OFS_CTRL), ctl(1, 0, MODE_TOGGLE, 0, 1), 0, q);
        bus(1, adr_of(1, OFS_CTRL), ctl(1, 1, MODE_TOGGLE, 0, 0), 0, q);
        bus(1, adr_of(2, OFS_CTRL), ctl(1, 1, MODE_TOGGLE, 0, 0), 0, q);
        period(0, 2 * c0);
        period(1, 8);
        period(2, 12);
        check("irq gated", cirq[0], 0);
        check("irq on", cirq[1], 1);
        bus(0, adr_of(0, OFS_FLAG), 1, '1, q);
        bus(0, adr_of(1, OFS_CTRL), 32'h4000_0000, 32'h4000_0000, q);
        for (int ch = 0; ch < 3; ch++) begin
            bus(1, adr_of(ch, OFS_CTRL), 32'h0400_0000, 0, q);
            bus(1, adr_of(ch, OFS_FLAG), 0, 0, q);
            bus(0, adr_of(ch, OFS_FLAG), 1, '1, q);
            bus(1, adr_of(ch, OFS_FLAG), 1, 0, q);
            bus(0, adr_of(ch, OFS_FLAG), 0, '1, q);
        end
        $display("test toggle sources done");
        // One-shot on channel three, then the shared interrupt and its mask.
        bus(1, adr_of(3, OFS_CMP), 6, 0, q);
        bus(1, adr_of(3, OFS_CTRL), ctl(1, 1, MODE_ONE_SHOT, 1, 0), 0, q);
        n = 0;
        while (cirq[3] !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check("one-shot irq", cirq[3], 1);
        bus(0, adr_of(3, OFS_CTRL), 0, 32'h4200_0000, q);
        bus(0, adr_of(3, OFS_SNAP), 0, '1, q);
        check("masked irq", irq, 0);
        bus(1, OFS_IRQ_MASK, 8, 0, q);
        repeat (2) @(posedge clk);
        check("irq out", irq, 1);
        check("irq rises", rises, 1);
        bus(1, OFS_IRQ_STAT, 8, 0, q);
        repeat (2) @(posedge clk);
        check("irq cleared", irq, 0);
        bus(0, OFS_IRQ_STAT, 0, 32'hf, q);
        // Periodic on channel three keeps counting and sets the cleared flag again.
        bus(1, adr_of(3, OFS_CTRL), ctl(1, 1, MODE_PERIODIC, 0, 0), 0, q);
        repeat (20) @(posedge clk);
        bus(0, adr_of(3, OFS_CTRL), 32'h6a00_0000, 32'h7a00_00ff, q);
        bus(0, adr_of(3, OFS_FLAG), 1, '1, q);
        check("periodic irq", irq, 1);
        // The fourth source code gives no ticks, so an enabled counter stays put.
        bus(1, adr_of(2, OFS_SRC), 32'h3, 0, q);
        bus(1, adr_of(2, OFS_CTRL), ctl(1, 0, MODE_CONTINUOUS, 1, 0), 0, q);
        repeat (10) @(posedge clk);
        bus(0, adr_of(2, OFS_SNAP), 0, '1, q);
        $display("test one-shot done");
        // Continuous counting runs past the match and keeps going on compare writes.
        bus(1, adr_of(0, OFS_CMP), 10, 0, q);
        bus(1, adr_of(0, OFS_CTRL), ctl(1, 0, MODE_CONTINUOUS, 1, 0), 0, q);
        repeat (30) @(posedge clk);
        bus(0, adr_of(0, OFS_SNAP), 0, 0, s1);
        check("past compare", s1 > 10, 1);
        bus(0, adr_of(0, OFS_FLAG), 1, '1, q);
        bus(1, adr_of(0, OFS_FLAG), 1, 0, q);
        bus(1, adr_of(0, OFS_CMP), s1 + 40, 0, q);
        bus(0, adr_of(0, OFS_SNAP), 0, 0, s2);
        check("no restart", s2 > s1, 1);
        repeat (40) @(posedge clk);
        bus(0, adr_of(0, OFS_FLAG), 1, '1, q);
        bus(1, adr_of(0, OFS_CTRL), ctl(0, 0, MODE_CONTINUOUS, 1, 0), 0, q);
        bus(0, adr_of(0, OFS_SNAP), 0, 0, s1);
        repeat (5) @(posedge clk);
        bus(0, adr_of(0, OFS_SNAP), 0, 0, s2);
        check("hold", s2, s1);
        $display("test continuous done");
        finish_test();
    end
endmodule // testbench

`default_nettype wire

// File: timer_channel.sv
// One timer channel: prescaler, 24-bit up-counter, compare and toggle.
`default_nettype none

module timer_channel import quad_timer_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    chan_if.chan bus
);
    logic [PSC_W-1:0] psc_q;
    logic [CNT_W-1:0] cnt_q;
    logic toggle_q;
    logic step;
    logic hit;
    logic [CNT_W-1:0] cnt_inc;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------------
    // Prescaler: one counter step every prescale plus one source ticks.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            psc_q <= '0;
        end else if (bus.restart) begin
            psc_q <= '0;
        end else if (bus.en && bus.src_tick) begin
            psc_q <= (psc_q == bus.prescale) ? '0 : psc_q + PSC_W'(1);
        end
    end

    assign step = bus.en && bus.src_tick && (psc_q == bus.prescale);
    assign cnt_inc = cnt_q + CNT_W'(1);
    assign hit = step && (cnt_inc == bus.compare);

    // Counter: reload on match except in continuous mode, which wraps.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
        end else if (bus.restart) begin
            cnt_q <= '0;
        end else if (hit && bus.mode != MODE_CONTINUOUS) begin
            cnt_q <= '0;
        end else if (step) begin
            cnt_q <= cnt_inc;
        end
    end

    // Square wave: flips at each match in toggle mode, so period is two match intervals.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            toggle_q <= 1'b0;
        end else if (bus.restart) begin
            toggle_q <= 1'b0;
        end else if (hit && bus.mode == MODE_TOGGLE) begin
            toggle_q <= !toggle_q;
        end
    end

    assign bus.count = cnt_q;
    assign bus.match = hit;
    assign bus.toggle = toggle_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_hold_when_off: assert property (
        (!bus.en && !bus.restart) |=> (cnt_q == $past(cnt_q)))
        else $error("counter moved while disabled");
    a_step_increment: assert property (
        (step && !hit && !bus.restart) |=> (cnt_q == $past(cnt_inc)))
        else $error("counter did not advance by one");
    a_reload_zero: assert property (
        (hit && bus.mode != MODE_CONTINUOUS && !bus.restart) |=> (cnt_q == '0))
        else $error("counter not reloaded on match");
    a_cont_passes: assert property (
        (hit && bus.mode == MODE_CONTINUOUS && !bus.restart)
        |=> (cnt_q == $past(bus.compare)))
        else $error("continuous counter did not pass the match");
    a_toggle_flip: assert property (
        (hit && bus.mode == MODE_TOGGLE && !bus.restart)
        |=> (toggle_q != $past(toggle_q)))
        else $error("toggle output did not flip");
endmodule // timer_channel

`default_nettype wire
